// [hdl/mpcr_config_bank.sv]
`timescale 1ns/10ps
`include "mpcr_regs.svh"

module mpcr_config_bank (
  // register port
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,

  // protection fields
  output logic [1:0] hot_current_cap_sel,
  output logic closed_loop_stuck_detect_en,
  output logic open_loop_stuck_detect_en,
  output logic missing_motor_detect_en,
  output logic torque_const_fault_detect_en,
  output logic speed_fault_detect_en,
  output logic stall_current_detect_en,
  output logic [3:0] accel_current_cap,
  output logic [2:0] stall_current_cap,
  output logic stall_cap_range_sel,

  // decoded currents in 100 mA units
  output logic [5:0] hot_cap_100ma,
  output logic [5:0] accel_cap_100ma,
  output logic [5:0] stall_cap_100ma,

  // drive-control fields
  output logic speed_input_kind,
  output logic chop_rate_select,
  output logic [1:0] torque_const_window,
  output logic inductive_surge_guard_en,
  output logic mechanical_surge_guard_en,
  output logic mechanical_surge_target,
  output logic probe_release_behaviour,
  output logic stay_open_loop,
  output logic [2:0] closed_loop_ramp,
  output logic [1:0] min_duty_floor,
  output logic [1:0] edge_speed_select
);

  // all state of the bank lives in one struct
  mpcr_pkg::mpcr_state_t state_reg;
  mpcr_pkg::mpcr_state_t state_next;
  logic prot_hit;
  logic drive_hit;
  logic prot_wr;
  logic drive_wr;
  logic [15:0] prot_cfg_next;
  logic [15:0] drive_cfg_next;
  logic [5:0] hot_cap_dec;
  logic [5:0] accel_cap_dec;
  logic [5:0] stall_cap_dec;
  logic [5:0] lock_en;

  // one address compare per register serves the write path
  assign prot_hit = (reg_addr == `MPCR_ADDR_PROT_LIMIT);
  assign drive_hit = (reg_addr == `MPCR_ADDR_DRIVE_CTRL);

  // writes elsewhere fall away silently; there is no error response
  assign prot_wr = reg_wr && prot_hit;
  assign drive_wr = reg_wr && drive_hit;

  // next words are formed outside the state process so that the decoder
  // can read them without a loop back through state_next
  assign prot_cfg_next =
    prot_wr ? reg_wdata : state_reg.prot_cfg;
  assign drive_cfg_next =
    drive_wr ? reg_wdata : state_reg.drive_cfg;

  // decoded from the next word so the currents line up
  // with the raw fields on the same cycle
  mpcr_limit_decode u_decode (
    .hot_current_cap_sel(
      prot_cfg_next[`MPCR_HOT_CAP_MSB:`MPCR_HOT_CAP_LSB]),
    .accel_current_cap(
      prot_cfg_next[`MPCR_ACCEL_CAP_MSB:`MPCR_ACCEL_CAP_LSB]),
    .stall_current_cap(
      prot_cfg_next[`MPCR_STALL_CAP_MSB:`MPCR_STALL_CAP_LSB]),
    .stall_cap_range_sel(prot_cfg_next[`MPCR_STALL_RANGE_BIT]),
    .hot_cap_100ma(hot_cap_dec),
    .accel_cap_100ma(accel_cap_dec),
    .stall_cap_100ma(stall_cap_dec)
  );

  // read data comes from the stored words, never from the next ones,
  // so a read in the same cycle as a write returns the old value
  always_comb begin
    state_next = state_reg;
    state_next.prot_cfg = prot_cfg_next;
    state_next.drive_cfg = drive_cfg_next;
    state_next.rvalid = 1'b0;
    if (reg_rd) begin
      state_next.rvalid = 1'b1;
      case (reg_addr)
        `MPCR_ADDR_PROT_LIMIT: begin
          state_next.rdata = state_reg.prot_cfg;
        end
        `MPCR_ADDR_DRIVE_CTRL: begin
          state_next.rdata = state_reg.drive_cfg;
        end
        default: begin
          // unmapped reads answer zero instead of being refused
          state_next.rdata = `MPCR_UNMAPPED_RDATA;
        end
      endcase
    end
    state_next.hot_cap_100ma = hot_cap_dec;
    state_next.accel_cap_100ma = accel_cap_dec;
    state_next.stall_cap_100ma = stall_cap_dec;
  end

  // the reset branch loads constants only; the stall cap starts at the
  // decode of code zero in the coarse range, matching the cleared word
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg.prot_cfg <= `MPCR_PROT_LIMIT_RST;
      state_reg.drive_cfg <= `MPCR_DRIVE_CTRL_RST;
      state_reg.rdata <= `MPCR_UNMAPPED_RDATA;
      state_reg.rvalid <= 1'b0;
      state_reg.hot_cap_100ma <= `MPCR_CAP_NONE;
      state_reg.accel_cap_100ma <= `MPCR_CAP_NONE;
      state_reg.stall_cap_100ma <= `MPCR_STALL_R0_2A5;
    end else begin
      state_reg <= state_next;
    end
  end

  // read data holds until the next read; valid is a one-cycle pulse
  assign reg_rdata = state_reg.rdata;
  assign reg_rvalid = state_reg.rvalid;

  // protection fields, static from the register
  // the overtemperature choice only matters once the warning is raised
  assign hot_current_cap_sel =
    state_reg.prot_cfg[`MPCR_HOT_CAP_MSB:`MPCR_HOT_CAP_LSB];

  // the six lock-detect enables sit side by side above the cap codes
  for (genvar gi = 0; gi < 6; gi++) begin : g_lock_en
    assign lock_en[gi] = state_reg.prot_cfg[`MPCR_STALL_I_BIT + gi];
  end

  assign closed_loop_stuck_detect_en =
    lock_en[`MPCR_CL_STUCK_BIT - `MPCR_STALL_I_BIT];
  assign open_loop_stuck_detect_en =
    lock_en[`MPCR_OL_STUCK_BIT - `MPCR_STALL_I_BIT];
  assign missing_motor_detect_en =
    lock_en[`MPCR_NO_MOTOR_BIT - `MPCR_STALL_I_BIT];
  assign torque_const_fault_detect_en =
    lock_en[`MPCR_KT_FAULT_BIT - `MPCR_STALL_I_BIT];
  assign speed_fault_detect_en =
    lock_en[`MPCR_SPD_FAULT_BIT - `MPCR_STALL_I_BIT];
  assign stall_current_detect_en =
    lock_en[0];

  // current-limit codes as stored; the decoded currents follow below
  assign accel_current_cap =
    state_reg.prot_cfg[`MPCR_ACCEL_CAP_MSB:`MPCR_ACCEL_CAP_LSB];
  assign stall_current_cap =
    state_reg.prot_cfg[`MPCR_STALL_CAP_MSB:`MPCR_STALL_CAP_LSB];
  assign stall_cap_range_sel =
    state_reg.prot_cfg[`MPCR_STALL_RANGE_BIT];

  // decoded currents, registered alongside the fields they come from
  assign hot_cap_100ma = state_reg.hot_cap_100ma;
  assign accel_cap_100ma = state_reg.accel_cap_100ma;
  assign stall_cap_100ma = state_reg.stall_cap_100ma;

  // drive-control fields
  // speed input kind and switching rate
  assign speed_input_kind =
    state_reg.drive_cfg[`MPCR_SPEED_KIND_BIT];
  assign chop_rate_select =
    state_reg.drive_cfg[`MPCR_CHOP_RATE_BIT];

  // torque-constant window for the abnormal-torque check
  assign torque_const_window =
    state_reg.drive_cfg[`MPCR_KT_WIN_MSB:`MPCR_KT_WIN_LSB];

  // surge guards and the release behaviour after position probing
  assign inductive_surge_guard_en =
    state_reg.drive_cfg[`MPCR_IND_SURGE_BIT];
  assign mechanical_surge_guard_en =
    state_reg.drive_cfg[`MPCR_MECH_SURGE_BIT];
  assign mechanical_surge_target =
    state_reg.drive_cfg[`MPCR_MECH_TARGET_BIT];
  assign probe_release_behaviour =
    state_reg.drive_cfg[`MPCR_PROBE_REL_BIT];

  // start-up, ramp and duty fields carry no behaviour of their own here
  assign stay_open_loop = state_reg.drive_cfg[`MPCR_STAY_OPEN_BIT];
  assign closed_loop_ramp =
    state_reg.drive_cfg[`MPCR_CL_RAMP_MSB:`MPCR_CL_RAMP_LSB];
  assign min_duty_floor =
    state_reg.drive_cfg[`MPCR_DUTY_FLOOR_MSB:`MPCR_DUTY_FLOOR_LSB];

  // phase-node edge speed
  assign edge_speed_select =
    state_reg.drive_cfg[`MPCR_EDGE_SPEED_MSB:`MPCR_EDGE_SPEED_LSB];

endmodule // mpcr_config_bank

// [hdl/mpcr_regs.svh]
`ifndef MPCR_REGS_SVH
`define MPCR_REGS_SVH

// register addresses on the internal register port
`define MPCR_ADDR_PROT_LIMIT 8'h94
`define MPCR_ADDR_DRIVE_CTRL 8'h95

// reset values
`define MPCR_PROT_LIMIT_RST 16'h0000
`define MPCR_DRIVE_CTRL_RST 16'h0000
`define MPCR_UNMAPPED_RDATA 16'h0000

// protection_limit_config field positions
`define MPCR_HOT_CAP_MSB 15
`define MPCR_HOT_CAP_LSB 14
`define MPCR_CL_STUCK_BIT 13
`define MPCR_OL_STUCK_BIT 12
`define MPCR_NO_MOTOR_BIT 11
`define MPCR_KT_FAULT_BIT 10
`define MPCR_SPD_FAULT_BIT 9
`define MPCR_STALL_I_BIT 8
`define MPCR_ACCEL_CAP_MSB 7
`define MPCR_ACCEL_CAP_LSB 4
`define MPCR_STALL_CAP_MSB 3
`define MPCR_STALL_CAP_LSB 1
`define MPCR_STALL_RANGE_BIT 0

// drive_control_config field positions
`define MPCR_SPEED_KIND_BIT 15
`define MPCR_CHOP_RATE_BIT 14
`define MPCR_KT_WIN_MSB 13
`define MPCR_KT_WIN_LSB 12
`define MPCR_IND_SURGE_BIT 11
`define MPCR_MECH_SURGE_BIT 10
`define MPCR_MECH_TARGET_BIT 9
`define MPCR_PROBE_REL_BIT 8
`define MPCR_STAY_OPEN_BIT 7
`define MPCR_CL_RAMP_MSB 6
`define MPCR_CL_RAMP_LSB 4
`define MPCR_DUTY_FLOOR_MSB 3
`define MPCR_DUTY_FLOOR_LSB 2
`define MPCR_EDGE_SPEED_MSB 1
`define MPCR_EDGE_SPEED_LSB 0

// current limits in units of 100 mA
`define MPCR_CAP_NONE 6'h00
`define MPCR_HOT_CAP_1A0 6'h0A
`define MPCR_HOT_CAP_1A6 6'h10
`define MPCR_HOT_CAP_2A0 6'h14
`define MPCR_ACCEL_STEP 6'h02
`define MPCR_STALL_R0_2A5 6'h19
`define MPCR_STALL_R0_1A9 6'h13
`define MPCR_STALL_R0_1A5 6'h0F
`define MPCR_STALL_R0_0A9 6'h09
`define MPCR_STALL_R1_STEP 6'h04

`endif

// [hdl/mpcr_pkg.sv]
package mpcr_pkg;

  // overtemperature current cap choices
  typedef enum logic [1:0] {
    MPCR_HOT_OFF = 2'h0,
    MPCR_HOT_1A0 = 2'h1,
    MPCR_HOT_1A6 = 2'h2,
    MPCR_HOT_2A0 = 2'h3
  } mpcr_hot_sel_t;

  typedef struct packed {
    logic [15:0] prot_cfg;
    logic [15:0] drive_cfg;
    logic [15:0] rdata;
    logic rvalid;
    logic [5:0] hot_cap_100ma;
    logic [5:0] accel_cap_100ma;
    logic [5:0] stall_cap_100ma;
  } mpcr_state_t;

endpackage

// [hdl/mpcr_limit_decode.sv]
`timescale 1ns/10ps
`include "mpcr_regs.svh"

// turns the coded current-limit fields into currents in 100 mA units
module mpcr_limit_decode (
  input wire logic [1:0] hot_current_cap_sel,
  input wire logic [3:0] accel_current_cap,
  input wire logic [2:0] stall_current_cap,
  input wire logic stall_cap_range_sel,
  output logic [5:0] hot_cap_100ma,
  output logic [5:0] accel_cap_100ma,
  output logic [5:0] stall_cap_100ma
);

  always_comb begin
    case (mpcr_pkg::mpcr_hot_sel_t'(hot_current_cap_sel))
      mpcr_pkg::MPCR_HOT_1A0: hot_cap_100ma = `MPCR_HOT_CAP_1A0;
      mpcr_pkg::MPCR_HOT_1A6: hot_cap_100ma = `MPCR_HOT_CAP_1A6;
      mpcr_pkg::MPCR_HOT_2A0: hot_cap_100ma = `MPCR_HOT_CAP_2A0;
      default: hot_cap_100ma = `MPCR_CAP_NONE;
    endcase
  end

  // zero gives no cap, otherwise n steps of 0.2 A
  assign accel_cap_100ma = 6'(accel_current_cap) * `MPCR_ACCEL_STEP;

  always_comb begin
    if (stall_cap_range_sel) begin
      // fine range, 0.4 A per code starting at 0.4 A
      stall_cap_100ma = (6'(stall_current_cap) + 6'h01) * `MPCR_STALL_R1_STEP;
    end else begin
      // coarse range ignores the top code bit
      case (stall_current_cap[1:0])
        2'h0: stall_cap_100ma = `MPCR_STALL_R0_2A5;
        2'h1: stall_cap_100ma = `MPCR_STALL_R0_1A9;
        2'h2: stall_cap_100ma = `MPCR_STALL_R0_1A5;
        default: stall_cap_100ma = `MPCR_STALL_R0_0A9;
      endcase
    end
  end

endmodule // mpcr_limit_decode

// [bench/mpcr_cfg_asserts.sv]
`timescale 1ns/10ps
module mpcr_cfg_asserts (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [1:0] hot_current_cap_sel,
  input wire logic [3:0] accel_current_cap,
  input wire logic [2:0] stall_current_cap,
  input wire logic stall_cap_range_sel,
  input wire logic [5:0] hot_cap_100ma,
  input wire logic [5:0] accel_cap_100ma,
  input wire logic [5:0] stall_cap_100ma,
  input wire logic speed_input_kind,
  input wire logic [1:0] edge_speed_select
);
  logic [5:0] hot_e;
  logic [5:0] stall_e;
  logic wr_p;
  logic wr_d;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  assign wr_p = reg_wr && reg_addr == 8'h94;
  assign wr_d = reg_wr && reg_addr == 8'h95;
  assign hot_e = hot_current_cap_sel == 2'h0 ? 6'h00 :
    hot_current_cap_sel == 2'h1 ? 6'h0A :
    hot_current_cap_sel == 2'h2 ? 6'h10 : 6'h14;
  // range 1 is a linear table, range 0 ignores the code's top bit
  assign stall_e = stall_cap_range_sel ?
    {1'h0, stall_current_cap, 2'h0} + 6'h04 :
    stall_current_cap[1:0] == 2'h0 ? 6'h19 :
    stall_current_cap[1:0] == 2'h1 ? 6'h13 :
    stall_current_cap[1:0] == 2'h2 ? 6'h0F : 6'h09;

  rd_unmapped_a: assert property (reg_rd && reg_addr[7:1] != 7'h4A
    |=> reg_rvalid && reg_rdata == 16'h0000) else $error("unmapped read");
  rvalid_pulse_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("stray read valid");
  hot_write_a: assert property (wr_p |=> hot_current_cap_sel ==
    $past(reg_wdata[15:14])) else $error("hot cap select not written");
  hot_hold_a: assert property (!wr_p |=>
    $stable(hot_current_cap_sel))
    else $error("hot cap select changed without write");
  stall_write_a: assert property (wr_p |=> stall_cap_range_sel ==
    $past(reg_wdata[0]) && stall_current_cap == $past(reg_wdata[3:1]))
    else $error("stall cap fields not written");
  accel_write_a: assert property (wr_p |=> accel_current_cap ==
    $past(reg_wdata[7:4])) else $error("accel cap not written");
  drive_write_a: assert property (wr_d |=> edge_speed_select ==
    $past(reg_wdata[1:0]) && speed_input_kind == $past(reg_wdata[15]))
    else $error("drive fields not written");
  hot_decode_a: assert property (hot_cap_100ma == hot_e)
    else $error("hot cap decode wrong");
  accel_decode_a: assert property (accel_cap_100ma ==
    {1'h0, accel_current_cap, 1'h0}) else $error("accel cap decode wrong");
  stall_decode_a: assert property (stall_cap_100ma == stall_e)
    else $error("stall cap decode wrong");
  cover property (wr_p ##1 reg_rd);
  cover property (wr_d && reg_rd);
  cover property (wr_p && reg_wdata[0]);
endmodule // mpcr_cfg_asserts

bind mpcr_config_bank mpcr_cfg_asserts u_chk (.*);

// [bench/motor_protection_config_regs_tb_top.sv]
`timescale 1ns/10ps
module motor_protection_config_regs_tb_top;
  logic sys_clk, reset, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, a;
  logic [15:0] reg_wdata, reg_rdata, prot_m, drv_m, prot_view, drv_view, d;
  logic [1:0] hot_current_cap_sel, torque_const_window, min_duty_floor;
  logic [1:0] edge_speed_select;
  logic closed_loop_stuck_detect_en, open_loop_stuck_detect_en;
  logic missing_motor_detect_en, torque_const_fault_detect_en;
  logic speed_fault_detect_en, stall_current_detect_en, stall_cap_range_sel;
  logic speed_input_kind, chop_rate_select, inductive_surge_guard_en;
  logic mechanical_surge_guard_en, mechanical_surge_target;
  logic probe_release_behaviour, stay_open_loop;
  logic [3:0] accel_current_cap;
  logic [2:0] stall_current_cap, closed_loop_ramp;
  logic [5:0] hot_cap_100ma, accel_cap_100ma, stall_cap_100ma;
  int failures, checked;

  mpcr_config_bank DUT (.*);

  assign prot_view = {hot_current_cap_sel, closed_loop_stuck_detect_en,
    open_loop_stuck_detect_en, missing_motor_detect_en,
    torque_const_fault_detect_en, speed_fault_detect_en,
    stall_current_detect_en, accel_current_cap, stall_current_cap,
    stall_cap_range_sel};
  assign drv_view = {speed_input_kind, chop_rate_select, torque_const_window,
    inductive_surge_guard_en, mechanical_surge_guard_en,
    mechanical_surge_target, probe_release_behaviour, stay_open_loop,
    closed_loop_ramp, min_duty_floor, edge_speed_select};

  always #12.5 sys_clk = ~sys_clk;

  function automatic logic [17:0] caps(input logic [15:0] p);
    logic [5:0] h;
    logic [5:0] s;
    h = p[15:14] == 2'h0 ? 6'h00 : p[15:14] == 2'h1 ? 6'h0A :
      p[15:14] == 2'h2 ? 6'h10 : 6'h14;
    s = p[2:1] == 2'h0 ? 6'h19 : p[2:1] == 2'h1 ? 6'h13 :
      p[2:1] == 2'h2 ? 6'h0F : 6'h09;
    if (p[0]) s = {1'h0, p[3:1], 2'h0} + 6'h04;
    return {h, 1'h0, p[7:4], 1'h0, s};
  endfunction

  task automatic chk(input string n, input logic [17:0] e,
    input logic [17:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // strobes stay up between calls so no signal is set twice in one step
  task automatic wr(input logic [7:0] ad, input logic [15:0] dt,
    input logic r);
    reg_addr = ad;
    reg_wdata = dt;
    reg_wr = 1'b1;
    reg_rd = r;
    @(negedge sys_clk);
    if (ad == 8'h94) prot_m = dt;
    if (ad == 8'h95) drv_m = dt;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [15:0] e);
    reg_addr = ad;
    reg_rd = 1'b1;
    reg_wr = 1'b0;
    @(negedge sys_clk);
    chk("reg_rvalid", 18'h00001, {17'h00000, reg_rvalid});
    chk("reg_rdata", {2'h0, e}, {2'h0, reg_rdata});
  endtask

  task automatic outs;
    chk("protection fields", {2'h0, prot_m}, {2'h0, prot_view});
    chk("drive fields", {2'h0, drv_m}, {2'h0, drv_view});
    chk("caps", caps(prot_m),
      {hot_cap_100ma, accel_cap_100ma, stall_cap_100ma});
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 26'h0000000;
    {failures, checked, prot_m, drv_m} = 96'h0;
    void'($urandom(32'hD98C52D3));
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    outs();
    rd(8'h94, 16'h0000);
    rd(8'h95, 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      wr(8'h94, {i[1:0], 6'h00, i[3:0], i[3:0]}, 1'b0);
      outs();
    end
    $display("test cap codes done");
    wr(8'h96, 16'hFFFF, 1'b0);
    wr(8'h00, 16'hFFFF, 1'b0);
    outs();
    rd(8'h96, 16'h0000);
    rd(8'h00, 16'h0000);
    d = prot_m;
    wr(8'h94, 16'hA5C3, 1'b1);
    chk("read during write", {2'h0, d}, {2'h0, reg_rdata});
    $display("test unmapped and collision done");
    for (int i = 0; i < 40; i++) begin
      a = {7'h4A, 1'($urandom_range(1))};
      wr(a, 16'($urandom), 1'b0);
      outs();
      if (i % 3 == 0) rd(a, a[0] ? drv_m : prot_m);
    end
    $display("test random traffic done");
    {reg_wr, reg_rd} = 2'h0;
    reset = 1'b1;
    @(negedge sys_clk);
    reset = 1'b0;
    {prot_m, drv_m} = 32'h00000000;
    outs();
    chk("reg_rvalid", 18'h00000, {17'h00000, reg_rvalid});
    chk("reg_rdata", 18'h00000, {2'h0, reg_rdata});
    rd(8'h95, 16'h0000);
    $display("test mid-run reset done");
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    tally_and_finish();
  end
endmodule // motor_protection_config_regs_tb_top
